// ---- verilog/prs_cfg.svh ----
// offsets, field positions, reset values and timing for the ramp controller
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH

`define PRS_OFS_PHASE 8'h6a
`define PRS_OFS_MODE 8'h6b
`define PRS_OFS_RANGE 8'h6c
`define PRS_OFS_DIV 8'h6d
`define PRS_OFS_STEPS 8'h6e
`define PRS_OFS_AMP 8'h6f
`define PRS_OFS_LAST 8'h6f

`define PRS_RST_PHASE 8'h00
`define PRS_RST_MODE 8'h00
`define PRS_RST_RANGE 8'h00
`define PRS_RST_DIV 8'h50
`define PRS_RST_STEPS 8'h11
`define PRS_RST_AMP 8'h24

`define PRS_PHASE_SEL_MSB 3
`define PRS_PHASE_SEL_LSB 2
`define PRS_FRAME_SYNC_BIT 1
`define PRS_PHASE_SYNC_BIT 0
`define PRS_PREDIV_BIT 5
`define PRS_MANUAL_BIT 4
`define PRS_RDM_EN_BIT 1
`define PRS_TRI_EN_BIT 0
`define PRS_RDM_RANGE_MSB 6
`define PRS_RDM_RANGE_LSB 4
`define PRS_TRI_CTRL_MSB 3
`define PRS_TRI_CTRL_LSB 0
`define PRS_FALL_MSB 7
`define PRS_FALL_LSB 4
`define PRS_RISE_MSB 3
`define PRS_RISE_LSB 0
`define PRS_AMPL_MSB 6
`define PRS_AMPL_LSB 5
`define PRS_LIMIT_MSB 4
`define PRS_LIMIT_LSB 0

`define PRS_AUTO_DIV 8'h50
`define PRS_AUTO_STEP 4'h1
`define PRS_AUTO_AMP 2'h1
`define PRS_LFSR_SEED 16'h0001

`define PRS_CLK_HZ 29'd250000000
`define PRS_REF_HZ 29'd61440000

`endif

// ---- verilog/prs_pkg.sv ----
// types shared by the ramp controller and its spread modulator
package prs_pkg;

	typedef struct packed {
		logic tri_en;
		logic rdm_en;
		logic [2:0] rdm_range;
		logic [4:0] tri_limit;
		logic [3:0] rise_step;
		logic [3:0] fall_step;
		logic [1:0] amplitude;
	} prs_spread_cfg_t;

	typedef enum logic {PRS_UP, PRS_DOWN} prs_dir_t;

endpackage

// ---- verilog/prs_spread_mod.sv ----
// triangle and random period offset generator
`include "prs_cfg.svh"
module prs_spread_mod (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// control
	input wire logic step_en,
	input wire prs_pkg::prs_spread_cfg_t cfg,
	// period offset
	output logic [7:0] offset
);
	logic [4:0] tri_r;
	logic [4:0] tri_nxt;
	prs_pkg::prs_dir_t dir_r;
	prs_pkg::prs_dir_t dir_nxt;
	logic [15:0] lfsr_r;
	logic [15:0] lfsr_nxt;
	logic [7:0] offset_nxt;
	logic [5:0] up_sum;
	logic [7:0] rdm_mask;
	logic [8:0] mix;
	logic [11:0] scaled;

	always_comb
	begin
		tri_nxt = tri_r;
		dir_nxt = dir_r;
		lfsr_nxt = lfsr_r;
		up_sum = {1'b0, tri_r} + {2'b00, cfg.rise_step};
		rdm_mask = 8'hff >> (3'd7 - cfg.rdm_range);
		if (!cfg.tri_en)
		begin
			tri_nxt = 5'h00;
			dir_nxt = prs_pkg::PRS_UP;
		end
		else if (step_en)
		begin
			case (dir_r)
				prs_pkg::PRS_UP:
					if (up_sum >= {1'b0, cfg.tri_limit}) // R14 R12
					begin
						tri_nxt = cfg.tri_limit;
						dir_nxt = prs_pkg::PRS_DOWN;
					end
					else
						tri_nxt = up_sum[4:0];
				default:
					if (tri_r <= {1'b0, cfg.fall_step}) // R11
					begin
						tri_nxt = 5'h00;
						dir_nxt = prs_pkg::PRS_UP;
					end
					else
						tri_nxt = tri_r - {1'b0, cfg.fall_step};
			endcase
		end
		if (step_en)
			lfsr_nxt = {lfsr_r[14:0],
				lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
		// no enable set leaves a fixed period
		mix = (cfg.tri_en ? {4'h0, tri_r} : 9'h000) // R9 R15
			+ (cfg.rdm_en ? {1'b0, lfsr_r[7:0] & rdm_mask} : 9'h000); // R8
		scaled = {3'h0, mix} << cfg.amplitude; // R13
		offset_nxt = (scaled[11:8] != 4'h0) ? 8'hff : scaled[7:0];
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			tri_r <= 5'h00;
			dir_r <= prs_pkg::PRS_UP;
			lfsr_r <= `PRS_LFSR_SEED;
			offset <= 8'h00;
		end
		else
		begin
			tri_r <= tri_nxt;
			dir_r <= dir_nxt;
			lfsr_r <= lfsr_nxt;
			offset <= offset_nxt;
		end
	end
endmodule

// ---- verilog/prs_ramp_ctrl.sv ----
// ramp phase, frame alignment and spread spectrum controller
//
// Behaviour
// R1: bits 3-2 of phase control pick ramp phase 0 to 3.
// R2: software gives all phased amplifiers the same ramp frequency and spread.
// R3: software writes the phase setting before commanding play.
// R4: bit 1 set aligns the ramp to incoming audio frame starts.
// R5: bit 0 enables ramp phase sync with other amplifiers; reset off.
// R6: manual mode pre-divide bit halves the spread source clock.
// R7: bit 4 switches spread control from automatic to manual parameters.
// R8: random spread enabled by bit 1, range from bits 6-4.
// R9: triangle spread enabled by bit 0, shape from bits 3-0.
// R10: manual ramp frequency is 61.44 MHz over divisor N, reset 0x50.
// R11: manual triangle fall step from bits 7-4, reset 1.
// R12: manual triangle rise step from bits 3-0, reset 1.
// R13: manual ramp amplitude from bits 6-5, reset 01.
// R14: manual triangle boundary from bits 4-0 of amplitude register.
// R15: both spread enables clear gives fixed frequency, no modulation.
// R16: automatic mode ignores all manual settings.
`include "prs_cfg.svh"
module prs_ramp_ctrl (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// timing references
	input wire logic ramp_run,
	input wire logic frame_start,
	input wire logic phase_sync_in,
	// ramp outputs
	output logic [9:0] ramp_count,
	output logic [9:0] ramp_period,
	output logic ramp_wrap,
	output logic [1:0] ramp_phase
);
	logic [7:0] regs_r [0:5];
	logic [7:0] regs_nxt [0:5];
	logic [7:0] rdata_nxt;
	logic [2:0] idx;
	logic in_map;

	logic [28:0] acc_r;
	logic [28:0] acc_nxt;
	logic [28:0] acc_sum;
	logic half_r;
	logic half_nxt;
	logic tick;
	logic ref_tick;

	logic [9:0] cnt_r;
	logic [9:0] cnt_nxt;
	logic [9:0] per_r;
	logic [9:0] per_nxt;
	logic wrap_nxt;
	logic [9:0] ph_off;
	logic [9:0] quarter;
	logic [9:0] base_n;
	logic [7:0] div_n;
	logic [7:0] offset;
	logic manual;
	logic align;
	prs_pkg::prs_spread_cfg_t scfg;

	// register decode
	always_comb
	begin
		in_map = (reg_addr >= `PRS_OFS_PHASE) && (reg_addr <= `PRS_OFS_LAST);
		idx = 3'(reg_addr - `PRS_OFS_PHASE);
		for (int i = 0; i < 6; i++)
			regs_nxt[i] = regs_r[i];
		if (reg_wr && in_map)
			regs_nxt[idx] = reg_wdata;
		rdata_nxt = reg_rdata;
		if (reg_rd)
		begin
			if (in_map)
				rdata_nxt = regs_r[idx];
			else
				rdata_nxt = 8'h00;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			regs_r[0] <= `PRS_RST_PHASE; // R5
			regs_r[1] <= `PRS_RST_MODE;
			regs_r[2] <= `PRS_RST_RANGE;
			regs_r[3] <= `PRS_RST_DIV; // R10
			regs_r[4] <= `PRS_RST_STEPS; // R11 R12
			regs_r[5] <= `PRS_RST_AMP; // R13
			reg_rdata <= 8'h00;
		end
		else
		begin
			for (int i = 0; i < 6; i++)
				regs_r[i] <= regs_nxt[i];
			reg_rdata <= rdata_nxt;
		end
	end

	// spread parameter selection
	always_comb
	begin
		manual = regs_r[1][`PRS_MANUAL_BIT]; // R7
		scfg.tri_en = regs_r[1][`PRS_TRI_EN_BIT]; // R9
		scfg.rdm_en = regs_r[1][`PRS_RDM_EN_BIT]; // R8
		scfg.rdm_range = regs_r[2][`PRS_RDM_RANGE_MSB:`PRS_RDM_RANGE_LSB]; // R8
		if (manual)
		begin
			div_n = regs_r[3]; // R10
			scfg.fall_step = regs_r[4][`PRS_FALL_MSB:`PRS_FALL_LSB]; // R11
			scfg.rise_step = regs_r[4][`PRS_RISE_MSB:`PRS_RISE_LSB]; // R12
			scfg.amplitude = regs_r[5][`PRS_AMPL_MSB:`PRS_AMPL_LSB]; // R13
			scfg.tri_limit = regs_r[5][`PRS_LIMIT_MSB:`PRS_LIMIT_LSB]; // R14
		end
		else
		begin
			div_n = `PRS_AUTO_DIV; // R16
			scfg.fall_step = `PRS_AUTO_STEP;
			scfg.rise_step = `PRS_AUTO_STEP;
			scfg.amplitude = `PRS_AUTO_AMP;
			scfg.tri_limit = {1'b0,
				regs_r[2][`PRS_TRI_CTRL_MSB:`PRS_TRI_CTRL_LSB]}; // R9
		end
		// divisor zero stands for 256
		base_n = (div_n == 8'h00) ? 10'h100 : {2'b00, div_n};
	end

	// 61.44 MHz reference enable, optionally halved
	always_comb
	begin
		acc_sum = acc_r + `PRS_REF_HZ;
		ref_tick = acc_sum >= `PRS_CLK_HZ;
		acc_nxt = ref_tick ? acc_sum - `PRS_CLK_HZ : acc_sum;
		half_nxt = ref_tick ? ~half_r : half_r;
		tick = ref_tick
			&& (!(manual && regs_r[1][`PRS_PREDIV_BIT]) || half_r); // R6 R16
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			acc_r <= 29'h0000000;
			half_r <= 1'b0;
		end
		else
		begin
			acc_r <= acc_nxt;
			half_r <= half_nxt;
		end
	end

	prs_spread_mod prs_spread_mod_inst (
		.clk(clk),
		.srst(srst),
		.step_en(wrap_nxt),
		.cfg(scfg),
		.offset(offset)
	);

	// ramp counter with phase placement
	always_comb
	begin
		ramp_phase = regs_r[0][`PRS_PHASE_SEL_MSB:`PRS_PHASE_SEL_LSB];
		quarter = {2'b00, per_r[9:2]};
		// offsets of zero, one, two or three quarters of the period
		case (ramp_phase) // R1
			2'h0: ph_off = 10'h000;
			2'h1: ph_off = quarter;
			2'h2: ph_off = {quarter[8:0], 1'b0};
			default: ph_off = 10'(quarter + {quarter[8:0], 1'b0});
		endcase
		// alignment pulses win over the reference tick
		align = (regs_r[0][`PRS_PHASE_SYNC_BIT] && phase_sync_in) // R5
			|| (regs_r[0][`PRS_FRAME_SYNC_BIT] && frame_start); // R4
		cnt_nxt = cnt_r;
		per_nxt = per_r;
		wrap_nxt = 1'b0;
		// held at the phase offset until play starts
		if (!ramp_run || align)
			cnt_nxt = ph_off; // R1 R3
		else if (tick)
		begin
			if (cnt_r >= per_r - 10'h001)
			begin
				cnt_nxt = 10'h000;
				wrap_nxt = 1'b1;
				per_nxt = 10'(base_n + {2'b00, offset}); // R10 R15
			end
			else
				cnt_nxt = cnt_r + 10'h001;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cnt_r <= 10'h000;
			per_r <= {2'b00, `PRS_AUTO_DIV};
			ramp_wrap <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			per_r <= per_nxt;
			ramp_wrap <= wrap_nxt;
		end
	end

	assign ramp_count = cnt_r;
	assign ramp_period = per_r;
endmodule

// ---- tb/prs_ramp_ctrl_monitor.sv ----
// port checker for the ramp controller
module prs_ramp_ctrl_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// references
	input wire logic frame_start,
	input wire logic phase_sync_in,
	// ramp
	input wire logic [9:0] ramp_count,
	input wire logic [9:0] ramp_period,
	input wire logic ramp_wrap,
	input wire logic [1:0] ramp_phase
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ph_r;
	logic [7:0] mode_r;
	logic [7:0] div_r;
	logic [9:0] div_exp;
	logic [7:0] mode_q;
	logic [7:0] mode_qq;
	logic [9:0] div_q;
	logic spread_off;
	logic auto_fixed;
	logic man_fixed;
	assign div_exp = (div_r == 8'h00) ? 10'h100 : {2'h0, div_r};
	// spread must be off for the period and for the offset behind it
	assign spread_off = (mode_q[1:0] == 2'h0) && (mode_qq[1:0] == 2'h0);
	assign auto_fixed = !mode_q[4] && spread_off;
	assign man_fixed = mode_q[4] && spread_off;
	// mode and divisor as they stood when the period was formed
	always_ff @(posedge clk)
	begin
		mode_q <= mode_r;
		mode_qq <= mode_q;
		div_q <= div_exp;
	end
	// shadow copies of the phase, mode and divisor registers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ph_r <= 8'h00;
			mode_r <= 8'h00;
			div_r <= 8'h50;
		end
		else if (reg_wr)
		begin
			if (reg_addr == 8'h6a) ph_r <= reg_wdata;
			if (reg_addr == 8'h6b) mode_r <= reg_wdata;
			if (reg_addr == 8'h6d) div_r <= reg_wdata;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	sequence s_wrap;
		ramp_wrap;
	endsequence
	sequence s_miss_rd;
		reg_rd && (reg_addr < 8'h6a || reg_addr > 8'h6f);
	endsequence
	sequence s_auto_wrap;
		ramp_wrap && auto_fixed;
	endsequence
	sequence s_man_wrap;
		ramp_wrap && man_fixed;
	endsequence
	sequence s_sync;
		phase_sync_in && ph_r[0] && ph_r[3:2] == 2'h0;
	endsequence
	sequence s_frame;
		frame_start && ph_r[1] && ph_r[3:2] == 2'h0;
	endsequence
	AST_PHASE_OUT: assert property (ramp_phase == ph_r[3:2])
		else $error("phase output differs from register");
	AST_WRAP_ONE: assert property (s_wrap |=> !ramp_wrap)
		else $error("wrap pulse too long");
	AST_WRAP_ZERO: assert property (s_wrap |-> ramp_count == 10'h000)
		else $error("count not zero at wrap");
	AST_PER_HOLD: assert property (!ramp_wrap && !$past(srst)
		|-> $stable(ramp_period))
		else $error("period changed without wrap");
	AST_AUTO_FIX: assert property (s_auto_wrap
		|-> ramp_period == 10'h050)
		else $error("automatic fixed period wrong");
	AST_MAN_DIV: assert property (s_man_wrap
		|-> ramp_period == div_q)
		else $error("manual period wrong");
	AST_SYNC: assert property (s_sync |=> ramp_count == 10'h000)
		else $error("phase sync not applied");
	AST_FRAME: assert property (s_frame |=> ramp_count == 10'h000)
		else $error("frame alignment not applied");
	AST_RD_MISS: assert property (s_miss_rd |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without read");
endmodule
bind prs_ramp_ctrl prs_ramp_ctrl_monitor prs_ramp_ctrl_monitor_inst (
	.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.frame_start(frame_start), .phase_sync_in(phase_sync_in),
	.ramp_count(ramp_count), .ramp_period(ramp_period),
	.ramp_wrap(ramp_wrap), .ramp_phase(ramp_phase));

// ---- tb/prs_frame_src.sv ----
// audio serial source model giving frame start pulses
module prs_frame_src #(parameter int FRAME_CYC = 64) (
	// clock
	input wire logic clk,
	// control
	input wire logic en,
	// frame timing
	output logic frame_start
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	initial frame_start = 1'b0;
	always @(posedge clk)
	begin
		#1;
		frame_start = (en && cnt == FRAME_CYC - 1);
		cnt = frame_start ? 0 : cnt + int'(en);
	end
endmodule

// ---- tb/test_prs_ramp_ctrl.sv ----
// self-checking bench for the ramp controller
module test_prs_ramp_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, ramp_run = 0;
	logic phase_sync_in = 0, src_en = 0, ramp_wrap, frame_start, bad;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
	logic [9:0] ramp_count, ramp_period, mx;
	logic [1:0] ramp_phase;
	logic [7:0] rstv [6] = '{8'h00, 8'h00, 8'h00, 8'h50, 8'h11, 8'h24};
	int n_fail = 0, n_tests = 0, t;
	initial forever #2 clk = ~clk;
	prs_ramp_ctrl prs_ramp_ctrl_inst (.clk(clk), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ramp_run(ramp_run),
		.frame_start(frame_start), .phase_sync_in(phase_sync_in),
		.ramp_count(ramp_count), .ramp_period(ramp_period),
		.ramp_wrap(ramp_wrap), .ramp_phase(ramp_phase));
	prs_frame_src prs_frame_src_inst (.clk(clk), .en(src_en),
		.frame_start(frame_start));
	task end_sim;
		if (n_fail == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [9:0] g, input logic [9:0] e);
		n_tests++;
		if (g !== e)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge clk);
		#1 reg_wr = 1'b0;
		@(posedge clk);
		#1;
	endtask
	task rd(input logic [7:0] a);
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1 reg_rd = 1'b0;
		d = reg_rdata;
		@(posedge clk);
		#1;
	endtask
	task wait_wrap;
		t = 0;
		do
		begin
			@(posedge clk);
			#1 t++;
		end while (ramp_wrap !== 1'b1 && t < 3000);
		if (t >= 3000)
		begin
			n_fail++;
			end_sim;
		end
	endtask
	task pulse_sync;
		repeat (50) @(posedge clk);
		#1 phase_sync_in = 1'b1;
		@(posedge clk);
		#1 phase_sync_in = 1'b0;
	endtask
	task t_regs;
		for (int i = 0; i < 6; i++)
		begin
			rd(8'(8'h6a + i));
			chk(10'(d), 10'(rstv[i]));
			wr(8'(8'h6a + i), 8'(8'h5a + i));
			rd(8'(8'h6a + i));
			chk(10'(d), 10'(8'h5a + i));
		end
		wr(8'h70, 8'hff);
		rd(8'h70);
		chk(10'(d), 10'h000);
		srst = 1'b1;
		repeat (2) @(posedge clk);
		#1 srst = 1'b0;
		rd(8'h6d);
		chk(10'(d), 10'h050);
		chk(ramp_period, 10'h050);
	endtask
	task t_phase;
		for (int k = 0; k < 4; k++)
		begin
			wr(8'h6a, 8'(k << 2));
			chk(ramp_count, 10'(20 * k));
			chk(10'(ramp_phase), 10'(k));
			chk(ramp_period, 10'h050);
		end
		wr(8'h6a, 8'h01);
		ramp_run = 1'b1;
		pulse_sync;
		chk(ramp_count, 10'h000);
		wr(8'h6a, 8'h00);
		pulse_sync;
		chk(10'(ramp_count == 10'h000), 10'h000);
		wr(8'h6a, 8'h02);
		src_en = 1'b1;
		t = 0;
		do
		begin
			@(posedge clk);
			#2 t++;
		end while (frame_start !== 1'b1 && t < 200);
		if (t >= 200)
		begin
			n_fail++;
			end_sim;
		end
		@(posedge clk);
		#1 src_en = 1'b0;
		chk(ramp_count, 10'h000);
	endtask
	task t_manual;
		wr(8'h6d, 8'h20);
		wr(8'h6b, 8'h10);
		wait_wrap;
		wait_wrap;
		chk(ramp_period, 10'h020);
		chk(10'(t < 200), 10'h001);
		wr(8'h6e, 8'h13);
		wr(8'h6f, 8'h05);
		wr(8'h6b, 8'h11);
		mx = 10'h000;
		bad = 1'b0;
		repeat (8)
		begin
			wait_wrap;
			if (ramp_period > mx) mx = ramp_period;
			if (ramp_period < 10'h020 || ramp_period > 10'h025) bad = 1'b1;
		end
		chk(10'(bad), 10'h000);
		chk(10'(mx > 10'h020), 10'h001);
		wr(8'h6b, 8'h30);
		wait_wrap;
		wait_wrap;
		chk(10'(t > 200), 10'h001);
		wr(8'h6b, 8'h00);
		wait_wrap;
		wait_wrap;
		chk(ramp_period, 10'h050);
	endtask
	task t_spread;
		wr(8'h6c, 8'h0f);
		wr(8'h6b, 8'h01);
		repeat (4) wait_wrap;
		chk(10'(ramp_period > 10'h050), 10'h001);
		wr(8'h6c, 8'h70);
		wr(8'h6b, 8'h02);
		bad = 1'b0;
		repeat (4)
		begin
			wait_wrap;
			if (ramp_period !== 10'h050) bad = 1'b1;
		end
		chk(10'(bad), 10'h001);
	endtask
	initial
	begin
		repeat (6) @(posedge clk);
		#1 srst = 1'b0;
		t_regs;
		t_phase;
		t_manual;
		t_spread;
		end_sim;
	end
endmodule
